// ===== rtl/video_output_sync_config.sv
// Summary of operation
// [RL1] Sync drive field sets strength of enable, horizontal and vertical pins; resets medium high.
// [RL2] Data drive field uses same codes, resets medium high, covers data, audio, control pins.
// [RL3] Pixel clock drive field sets clock pin strength by clock rate; resets medium high.
// [RL4] Vertical source bit one drives vertical sync on shared pin, zero drives field.
// [RL5] Field select bit zero drives data enable on enable pin, one drives field.
// [RL6] Pixel clock invert flips only the pixel clock pin, in every mode.
// [RL7] Horizontal polarity bit zero gives negative sync, one gives positive sync.
// [RL8] Vertical polarity bit zero gives negative shared pin, one gives positive.
// [RL9] Field polarity bit zero keeps field or enable positive, one inverts it.
// [RL10] Video synthesizer removes deep colour and repetition; pin shows divided clock.
// [RL11] Video synthesizer locks in less than one video frame.
// [RL12] Audio clock is link clock divided by CTS and multiplied by N; the pin toggles once per CTS step, so it runs at half that rate.
// [RL13] Audio synthesizer locks within five milliseconds after a valid regeneration packet.
// [RL14] Software programs crystal select to match the fitted crystal.
// [RL15] Primary mode 0101 is component, 0110 graphics and reset value, others reserved.
// [RL16] Video standard resets to 000010 and is read together with primary mode.
// [RL17] Software should use mode 0x06 and standard 0x02 without free run or decimation.
// [RL18] Any stream is decoded; video goes to component path, audio to audio pins.
// [RL19] Software must not program reserved codes into drive, mode or standard fields.
module video_output_sync_config
    import video_output_pkg::*;
#(
    parameter int PIXEL_WIDTH = 36,
    parameter int AUDIO_WIDTH = 6,
    parameter int AUDIO_LOCK = AUDIO_LOCK_CYCLES,
    parameter int VIDEO_LOCK = VIDEO_LOCK_CYCLES
)
(
    input wire logic clock,
    input wire logic srst,
    input wire logic [7:0] regAddress,
    input wire logic [7:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regReadData,
    input wire syncBundle_s syncIn,
    input wire logic [PIXEL_WIDTH-1:0] pixelIn,
    input wire logic [AUDIO_WIDTH-1:0] audioIn,
    input wire logic linkClockTick,
    input wire logic linkPresent,
    input wire logic [4:0] bitsPerColour,
    input wire logic [3:0] pixelRepetition,
    input wire logic acrPacketValid,
    input wire logic [19:0] acrN,
    input wire logic [19:0] acrCts,
    output logic horizontalSync,
    output logic verticalOrFieldPin,
    output logic dataEnablePin,
    output logic pixelClockOutput,
    output logic [PIXEL_WIDTH-1:0] pixelOut,
    output logic [AUDIO_WIDTH-1:0] audioOutputPins,
    output logic audioMasterClock,
    output driveStrength_s driveStrength,
    output logic [1:0] crystalFrequencySelect,
    output logic componentMode,
    output logic graphicsMode,
    output logic [5:0] videoStandard,
    output logic videoLocked,
    output logic audioLocked
);

    logic [5:0] videoStandardSelect;
    logic [3:0] primaryModeSelect;
    logic [1:0] crystalSelect;
    logic fieldOnEnablePinSelect;
    logic pixelClockInvert;
    logic horizontalSyncPolarity;
    logic verticalSyncPolarity;
    logic fieldEnablePolarity;
    logic verticalPinSourceSelect;
    logic [1:0] syncPinDriveStrength;
    logic [1:0] pixelClockDriveStrength;
    logic [1:0] dataPinDriveStrength;
    logic [8:0] videoPhase;
    logic [8:0] next_videoPhase;
    logic [8:0] videoThreshold;
    logic pixelTick;
    logic pixelClockRaw;
    logic [20:0] audioPhase;
    logic [20:0] next_audioPhase;
    logic audioTick;
    logic audioClockRaw;
    logic linkSeen;
    logic linkStart;
    logic videoLockRaw;
    logic audioLockRaw;

    function automatic logic [7:0] field_in_byte(input logic [5:0] value, input int lsb, input int width);
        logic [7:0] shifted;
        shifted = 8'h00;
        for (int i = 0; i < width; i++)
        begin
            shifted[lsb + i] = value[i];
        end
        return shifted;
    endfunction

    function automatic logic pin_polarity(input logic level, input logic invert);
        return level ^ invert;
    endfunction

    // Register writes; reserved codes are stored as written.
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            videoStandardSelect <= VIDEO_STANDARD_RESET; // [RL16]
            primaryModeSelect <= PRIMARY_MODE_RESET; // [RL15]
            crystalSelect <= CRYSTAL_RESET;
            fieldOnEnablePinSelect <= FIELD_SELECT_RESET;
            pixelClockInvert <= PIXEL_INVERT_RESET;
            horizontalSyncPolarity <= HSYNC_POLARITY_RESET;
            verticalSyncPolarity <= VSYNC_POLARITY_RESET;
            fieldEnablePolarity <= FIELD_POLARITY_RESET;
            verticalPinSourceSelect <= VERTICAL_SOURCE_RESET;
            syncPinDriveStrength <= DRIVE_RESET; // [RL1]
            pixelClockDriveStrength <= DRIVE_RESET; // [RL3]
            dataPinDriveStrength <= DRIVE_RESET; // [RL2]
        end
        else if (regWrite)
        begin
            case (regAddress)
                VIDEO_STANDARD_OFFSET: videoStandardSelect <= regWriteData[VIDEO_STANDARD_LSB +: 6]; // [RL16]
                PRIMARY_MODE_OFFSET: primaryModeSelect <= regWriteData[PRIMARY_MODE_LSB +: 4]; // [RL15]
                CRYSTAL_OFFSET: crystalSelect <= regWriteData[CRYSTAL_LSB +: 2]; // [RL14]
                FIELD_SELECT_OFFSET: fieldOnEnablePinSelect <= regWriteData[FIELD_SELECT_BIT];
                POLARITY_OFFSET:
                begin
                    pixelClockInvert <= regWriteData[PIXEL_INVERT_BIT];
                    horizontalSyncPolarity <= regWriteData[HSYNC_POLARITY_BIT];
                    verticalSyncPolarity <= regWriteData[VSYNC_POLARITY_BIT];
                    fieldEnablePolarity <= regWriteData[FIELD_POLARITY_BIT];
                    verticalPinSourceSelect <= regWriteData[VERTICAL_SOURCE_BIT];
                end
                DRIVE_OFFSET:
                begin
                    syncPinDriveStrength <= regWriteData[SYNC_DRIVE_LSB +: 2]; // [RL1]
                    pixelClockDriveStrength <= regWriteData[CLOCK_DRIVE_LSB +: 2]; // [RL3]
                    dataPinDriveStrength <= regWriteData[DATA_DRIVE_LSB +: 2]; // [RL2]
                end
                default:
                begin
                end
            endcase
        end
    end

    // Read data is registered; unmapped offsets and unused bits read as zero.
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            regReadData <= 8'h00;
        end
        else if (regRead)
        begin
            case (regAddress)
                VIDEO_STANDARD_OFFSET: regReadData <= field_in_byte(videoStandardSelect, VIDEO_STANDARD_LSB, 6);
                PRIMARY_MODE_OFFSET: regReadData <= field_in_byte({2'h0, primaryModeSelect}, PRIMARY_MODE_LSB, 4);
                CRYSTAL_OFFSET: regReadData <= field_in_byte({4'h0, crystalSelect}, CRYSTAL_LSB, 2);
                FIELD_SELECT_OFFSET:
                begin
                    regReadData <= field_in_byte({5'h00, fieldOnEnablePinSelect}, FIELD_SELECT_BIT, 1);
                end
                POLARITY_OFFSET:
                begin
                    regReadData <= field_in_byte({5'h00, verticalPinSourceSelect}, VERTICAL_SOURCE_BIT, 1)
                        | field_in_byte({5'h00, fieldEnablePolarity}, FIELD_POLARITY_BIT, 1)
                        | field_in_byte({5'h00, verticalSyncPolarity}, VSYNC_POLARITY_BIT, 1)
                        | field_in_byte({5'h00, horizontalSyncPolarity}, HSYNC_POLARITY_BIT, 1)
                        | field_in_byte({5'h00, pixelClockInvert}, PIXEL_INVERT_BIT, 1);
                end
                DRIVE_OFFSET:
                begin
                    regReadData <= field_in_byte({4'h0, dataPinDriveStrength}, DATA_DRIVE_LSB, 2)
                        | field_in_byte({4'h0, pixelClockDriveStrength}, CLOCK_DRIVE_LSB, 2)
                        | field_in_byte({4'h0, syncPinDriveStrength}, SYNC_DRIVE_LSB, 2);
                end
                default: regReadData <= 8'h00;
            endcase
        end
    end

    // Configuration that the pads and the processing path pick up.
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            driveStrength <= '{data: DRIVE_RESET, pixelClock: DRIVE_RESET, sync: DRIVE_RESET};
            crystalFrequencySelect <= CRYSTAL_RESET;
            componentMode <= 1'b0;
            graphicsMode <= 1'b1;
            videoStandard <= VIDEO_STANDARD_RESET;
        end
        else
        begin
            driveStrength.sync <= syncPinDriveStrength; // [RL1]
            driveStrength.data <= dataPinDriveStrength; // [RL2]
            driveStrength.pixelClock <= pixelClockDriveStrength; // [RL3]
            crystalFrequencySelect <= crystalSelect; // [RL14]
            componentMode <= (primaryModeSelect == MODE_HDMI_COMPONENT); // [RL15]
            graphicsMode <= (primaryModeSelect == MODE_HDMI_GRAPHICS); // [RL15]
            videoStandard <= videoStandardSelect; // [RL16]
        end
    end

    // Sync conditioning; the internal syncs are active high.
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            horizontalSync <= 1'b1;
            verticalOrFieldPin <= 1'b1;
            dataEnablePin <= 1'b0;
        end
        else
        begin
            horizontalSync <= pin_polarity(syncIn.hsync, !horizontalSyncPolarity); // [RL7]
            verticalOrFieldPin <= pin_polarity(verticalPinSourceSelect ? syncIn.vsync : syncIn.field, // [RL4]
                !verticalSyncPolarity); // [RL8]
            dataEnablePin <= pin_polarity(fieldOnEnablePinSelect ? syncIn.field : syncIn.dataEnable, // [RL5]
                fieldEnablePolarity); // [RL9]
        end
    end

    // Decoded video and audio pass through whatever the mode codes say.
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            pixelOut <= '0;
            audioOutputPins <= '0;
        end
        else
        begin
            pixelOut <= pixelIn; // [RL18]
            audioOutputPins <= audioIn; // [RL18]
        end
    end

    // Each link tick carries eight bits per channel; a pixel needs the colour depth times one plus the repetition count.
    always_comb
    begin
        videoThreshold = 9'(bitsPerColour) * 9'({1'b0, pixelRepetition} + 5'h01);
        next_videoPhase = videoPhase + 9'(LINK_BITS_PER_TICK);
        pixelTick = 1'b0;
        if (next_videoPhase >= videoThreshold)
        begin
            next_videoPhase = next_videoPhase - videoThreshold;
            pixelTick = 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst || !linkPresent)
        begin
            videoPhase <= '0;
            pixelClockRaw <= 1'b0;
        end
        else if (linkClockTick && videoThreshold != 9'h000)
        begin
            videoPhase <= next_videoPhase; // [RL10]
            if (pixelTick)
            begin
                pixelClockRaw <= !pixelClockRaw; // [RL10]
            end
        end
    end

    // The clock pin is the halved pixel rate; invert touches nothing else.
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            pixelClockOutput <= 1'b0;
        end
        else
        begin
            pixelClockOutput <= pixelClockRaw ^ pixelClockInvert; // [RL6]
        end
    end

    // Fractional divider: N added per link tick, CTS taken off per audio edge.
    always_comb
    begin
        next_audioPhase = audioPhase + {1'b0, acrN};
        audioTick = 1'b0;
        if (next_audioPhase >= {1'b0, acrCts})
        begin
            next_audioPhase = next_audioPhase - {1'b0, acrCts};
            audioTick = 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst || !linkPresent)
        begin
            audioPhase <= '0;
            audioClockRaw <= 1'b0;
            audioMasterClock <= 1'b0;
        end
        else
        begin
            if (linkClockTick && acrCts != 20'h00000)
            begin
                audioPhase <= next_audioPhase; // [RL12]
                if (audioTick)
                begin
                    audioClockRaw <= !audioClockRaw; // [RL12]
                end
            end
            audioMasterClock <= audioClockRaw;
        end
    end

    // Video lock starts with the first link tick after the link appears; audio lock starts with a valid packet.
    always_ff @(posedge clock)
    begin
        if (srst || !linkPresent)
        begin
            linkSeen <= 1'b0;
        end
        else if (linkClockTick)
        begin
            linkSeen <= 1'b1;
        end
    end

    assign linkStart = linkClockTick && !linkSeen && linkPresent;

    synth_lock_timer #(
        .LOCK_CYCLES(VIDEO_LOCK)
    ) videoLockTimer (
        .clock(clock),
        .srst(srst),
        .start(linkStart), // [RL11]
        .drop(!linkPresent),
        .locked(videoLockRaw)
    );

    synth_lock_timer #(
        .LOCK_CYCLES(AUDIO_LOCK)
    ) audioLockTimer (
        .clock(clock),
        .srst(srst),
        .start(acrPacketValid && linkPresent), // [RL13]
        .drop(!linkPresent),
        .locked(audioLockRaw)
    );

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            videoLocked <= 1'b0;
            audioLocked <= 1'b0;
        end
        else
        begin
            videoLocked <= videoLockRaw; // [RL11]
            audioLocked <= audioLockRaw; // [RL13]
        end
    end

endmodule // video_output_sync_config

// ===== rtl/video_output_pkg.sv
package video_output_pkg;

    // Register offsets.
    localparam logic [7:0] VIDEO_STANDARD_OFFSET = 8'h00;
    localparam logic [7:0] PRIMARY_MODE_OFFSET = 8'h01;
    localparam logic [7:0] CRYSTAL_OFFSET = 8'h04;
    localparam logic [7:0] FIELD_SELECT_OFFSET = 8'h05;
    localparam logic [7:0] POLARITY_OFFSET = 8'h06;
    localparam logic [7:0] DRIVE_OFFSET = 8'h14;

    // Field positions.
    localparam int VIDEO_STANDARD_LSB = 0;
    localparam int PRIMARY_MODE_LSB = 0;
    localparam int CRYSTAL_LSB = 1;
    localparam int FIELD_SELECT_BIT = 4;
    localparam int PIXEL_INVERT_BIT = 0;
    localparam int HSYNC_POLARITY_BIT = 1;
    localparam int VSYNC_POLARITY_BIT = 2;
    localparam int FIELD_POLARITY_BIT = 3;
    localparam int VERTICAL_SOURCE_BIT = 7;
    localparam int SYNC_DRIVE_LSB = 0;
    localparam int CLOCK_DRIVE_LSB = 2;
    localparam int DATA_DRIVE_LSB = 4;

    // Reset values.
    localparam logic [5:0] VIDEO_STANDARD_RESET = 6'h02;
    localparam logic [3:0] PRIMARY_MODE_RESET = 4'h6;
    localparam logic [1:0] CRYSTAL_RESET = 2'h1;
    localparam logic FIELD_SELECT_RESET = 1'h0;
    localparam logic PIXEL_INVERT_RESET = 1'h0;
    localparam logic HSYNC_POLARITY_RESET = 1'h0;
    localparam logic VSYNC_POLARITY_RESET = 1'h0;
    localparam logic FIELD_POLARITY_RESET = 1'h0;
    localparam logic VERTICAL_SOURCE_RESET = 1'h1;
    localparam logic [1:0] DRIVE_RESET = 2'h2;

    // Drive strength codes.
    localparam logic [1:0] DRIVE_RESERVED = 2'h0;
    localparam logic [1:0] DRIVE_MEDIUM_LOW = 2'h1;
    localparam logic [1:0] DRIVE_MEDIUM_HIGH = 2'h2;
    localparam logic [1:0] DRIVE_HIGH = 2'h3;

    typedef enum logic [3:0] {
        MODE_HDMI_COMPONENT = 4'b0101,
        MODE_HDMI_GRAPHICS = 4'b0110
    } primaryMode_e;

    // Timing.
    localparam int CLOCK_HZ = 20_000_000;
    localparam int AUDIO_LOCK_MS = 5;
    localparam int AUDIO_LOCK_CYCLES = AUDIO_LOCK_MS * (CLOCK_HZ / 1000) - 2;
    localparam int VIDEO_FRAME_US = 16_683;
    localparam int VIDEO_LOCK_CYCLES = VIDEO_FRAME_US * (CLOCK_HZ / 1_000_000) - 3;

    // Link word counts: one link tick carries eight bits of one colour channel.
    localparam int LINK_BITS_PER_TICK = 8;

    typedef struct packed {
        logic hsync;
        logic vsync;
        logic field;
        logic dataEnable;
    } syncBundle_s;

    typedef struct packed {
        logic [1:0] data;
        logic [1:0] pixelClock;
        logic [1:0] sync;
    } driveStrength_s;

endpackage

// ===== rtl/synth_lock_timer.sv
module synth_lock_timer
    import video_output_pkg::*;
#(
    parameter int LOCK_CYCLES = 100000
)
(
    input wire logic clock,
    input wire logic srst,
    input wire logic start,
    input wire logic drop,
    output logic locked
);

    localparam int COUNT_WIDTH = $clog2(LOCK_CYCLES + 1);
    localparam logic [COUNT_WIDTH-1:0] LAST_COUNT = COUNT_WIDTH'(LOCK_CYCLES - 1);

    logic [COUNT_WIDTH-1:0] count;
    logic running;

    always_ff @(posedge clock)
    begin
        if (srst || drop)
        begin
            count <= '0;
            running <= 1'b0;
            locked <= 1'b0;
        end
        else if (start && !locked)
        begin
            count <= '0;
            running <= 1'b1;
        end
        else if (running)
        begin
            if (count == LAST_COUNT)
            begin
                running <= 1'b0;
                locked <= 1'b1;
            end
            else
            begin
                count <= count + 1'b1;
            end
        end
    end

endmodule // synth_lock_timer

// ===== tb/video_output_chk.sv
module video_output_chk
    import video_output_pkg::*;
#(
    parameter int AUDIO_LOCK = 16,
    parameter int VIDEO_LOCK = 32
)
(
    input wire logic clock,
    input wire logic srst,
    input wire logic [7:0] regAddress,
    input wire logic [7:0] regWriteData,
    input wire logic regWrite,
    input wire syncBundle_s syncIn,
    input wire logic linkClockTick,
    input wire logic linkPresent,
    input wire logic acrPacketValid,
    input wire logic horizontalSync,
    input wire logic verticalOrFieldPin,
    input wire logic dataEnablePin,
    input wire logic pixelClockOutput,
    input wire driveStrength_s driveStrength,
    input wire logic [1:0] crystalFrequencySelect,
    input wire logic componentMode,
    input wire logic graphicsMode,
    input wire logic [5:0] videoStandard,
    input wire logic videoLocked,
    input wire logic audioLocked
);
    // Bounds leave room for the lock output register after the timer.
    localparam int AUDIO_BOUND = AUDIO_LOCK + 4;
    localparam int VIDEO_BOUND = VIDEO_LOCK + 4;
    logic [7:0] polarity;
    logic fieldSelect;
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    always_ff @(posedge clock)
        polarity <= srst ? 8'h80 : (regWrite && regAddress == POLARITY_OFFSET) ? regWriteData : polarity;
    always_ff @(posedge clock)
        fieldSelect <= srst ? 1'b0 : (regWrite && regAddress == FIELD_SELECT_OFFSET) ? regWriteData[4] : fieldSelect;
    hsync_polarity_a: assert property (1'b1 |=> horizontalSync == $past(syncIn.hsync ~^ polarity[1]))
        else $error("horizontal sync level wrong");
    vertical_pin_a: assert property (1'b1 |=>
        verticalOrFieldPin == $past((polarity[7] ? syncIn.vsync : syncIn.field) ~^ polarity[2]))
        else $error("vertical pin level wrong");
    enable_pin_a: assert property (1'b1 |=>
        dataEnablePin == $past((fieldSelect ? syncIn.field : syncIn.dataEnable) ^ polarity[3]))
        else $error("enable pin level wrong");
    drive_write_a: assert property (regWrite && regAddress == DRIVE_OFFSET |->
        ##2 driveStrength == $past(regWriteData[5:0], 2))
        else $error("drive strength not updated");
    mode_decode_a: assert property (regWrite && regAddress == PRIMARY_MODE_OFFSET |->
        ##2 componentMode == ($past(regWriteData[3:0], 2) == 4'h5) &&
        graphicsMode == ($past(regWriteData[3:0], 2) == 4'h6))
        else $error("mode decode wrong");
    reset_values_a: assert property ($fell(srst) |-> videoStandard == VIDEO_STANDARD_RESET &&
        driveStrength == {3{DRIVE_RESET}} && crystalFrequencySelect == CRYSTAL_RESET && graphicsMode && !componentMode)
        else $error("reset values wrong");
    audio_lock_a: assert property (acrPacketValid && linkPresent |-> ##[1:AUDIO_BOUND] (audioLocked || !linkPresent))
        else $error("audio lock too late");
    video_lock_a: assert property (linkClockTick && linkPresent |-> ##[1:VIDEO_BOUND] (videoLocked || !linkPresent))
        else $error("video lock too late");
    link_drop_a: assert property (!linkPresent [*3] |-> !videoLocked && !audioLocked)
        else $error("lock held without link");
    pixel_invert_a: assert property (!linkPresent [*3] |-> pixelClockOutput == $past(polarity[0]))
        else $error("pixel clock polarity wrong");
    cover property (regWrite && regAddress == POLARITY_OFFSET);
    cover property (videoLocked && audioLocked);
    cover property (componentMode);
endmodule // video_output_chk

bind video_output_sync_config video_output_chk #(.AUDIO_LOCK(AUDIO_LOCK), .VIDEO_LOCK(VIDEO_LOCK)) checker_inst (
    .clock(clock), .srst(srst), .regAddress(regAddress), .regWriteData(regWriteData), .regWrite(regWrite),
    .syncIn(syncIn), .linkClockTick(linkClockTick), .linkPresent(linkPresent), .acrPacketValid(acrPacketValid),
    .horizontalSync(horizontalSync), .verticalOrFieldPin(verticalOrFieldPin), .dataEnablePin(dataEnablePin),
    .pixelClockOutput(pixelClockOutput), .driveStrength(driveStrength), .crystalFrequencySelect(crystalFrequencySelect),
    .componentMode(componentMode), .graphicsMode(graphicsMode), .videoStandard(videoStandard),
    .videoLocked(videoLocked), .audioLocked(audioLocked));

// ===== tb/video_sink_model.sv
module video_sink_model
(
    input wire logic clock,
    input wire logic clear,
    input wire logic pixelClockOutput,
    input wire logic audioMasterClock,
    output logic [15:0] pixelEdges,
    output logic [15:0] audioEdges
);
    timeunit 1ns;
    timeprecision 1ns;
    logic lastPixel;
    logic lastAudio;
    // The sink latches on rising clock edges, so only those are counted.
    always_ff @(posedge clock)
    begin
        lastPixel <= pixelClockOutput;
        lastAudio <= audioMasterClock;
        pixelEdges <= clear ? 16'h0 : pixelEdges + 16'(pixelClockOutput && !lastPixel);
        audioEdges <= clear ? 16'h0 : audioEdges + 16'(audioMasterClock && !lastAudio);
    end
endmodule // video_sink_model

// ===== tb/testbench.sv
module testbench
    import video_output_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdExp;
        logic [3:0] sync;
        logic [2:0] pins;
    } row_s;
    logic clock, srst, regWrite, regRead, linkClockTick, linkPresent, acrPacketValid, countClear;
    logic [7:0] regAddress, regWriteData, regReadData;
    syncBundle_s syncIn;
    logic [35:0] pixelIn, pixelOut;
    logic [5:0] audioIn, audioOutputPins, videoStandard;
    logic [4:0] bitsPerColour;
    logic [3:0] pixelRepetition;
    logic [19:0] acrN, acrCts;
    logic horizontalSync, verticalOrFieldPin, dataEnablePin, pixelClockOutput, audioMasterClock;
    logic componentMode, graphicsMode, videoLocked, audioLocked;
    driveStrength_s driveStrength;
    logic [1:0] crystalFrequencySelect;
    logic [15:0] pixelEdges, audioEdges;
    int failures = 0;
    int checked = 0;
    row_s rows [13] = '{'{8'h06, 8'h00, 8'h00, 4'hA, 3'h0}, '{8'h06, 8'h86, 8'h86, 4'hC, 3'h6},
        '{8'h05, 8'h10, 8'h10, 4'h3, 3'h1}, '{8'h06, 8'h09, 8'h09, 4'h6, 3'h4}, '{8'h05, 8'hEF, 8'h00, 4'h1, 3'h6},
        '{8'h14, 8'h3F, 8'h3F, 4'h0, 3'h7}, '{8'h14, 8'h15, 8'h15, 4'h0, 3'h7}, '{8'h00, 8'hC5, 8'h05, 4'h0, 3'h7},
        '{8'h01, 8'h05, 8'h05, 4'h0, 3'h7}, '{8'h04, 8'hFF, 8'h06, 4'h0, 3'h7}, '{8'h20, 8'hFF, 8'h00, 4'h0, 3'h7},
        '{8'h01, 8'h06, 8'h06, 4'h0, 3'h7}, '{8'h00, 8'h02, 8'h02, 4'h0, 3'h7}};
    logic [7:0] resetAddr [6] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06, 8'h14};
    logic [7:0] resetData [6] = '{8'h02, 8'h06, 8'h02, 8'h00, 8'h80, 8'h2A};

    video_output_sync_config #(.AUDIO_LOCK(16), .VIDEO_LOCK(32)) DUT (.clock(clock), .srst(srst),
        .regAddress(regAddress), .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
        .regReadData(regReadData), .syncIn(syncIn), .pixelIn(pixelIn), .audioIn(audioIn),
        .linkClockTick(linkClockTick), .linkPresent(linkPresent), .bitsPerColour(bitsPerColour),
        .pixelRepetition(pixelRepetition), .acrPacketValid(acrPacketValid), .acrN(acrN), .acrCts(acrCts),
        .horizontalSync(horizontalSync), .verticalOrFieldPin(verticalOrFieldPin), .dataEnablePin(dataEnablePin),
        .pixelClockOutput(pixelClockOutput), .pixelOut(pixelOut), .audioOutputPins(audioOutputPins),
        .audioMasterClock(audioMasterClock), .driveStrength(driveStrength),
        .crystalFrequencySelect(crystalFrequencySelect), .componentMode(componentMode), .graphicsMode(graphicsMode),
        .videoStandard(videoStandard), .videoLocked(videoLocked), .audioLocked(audioLocked));

    video_sink_model sink (.clock(clock), .clear(countClear), .pixelClockOutput(pixelClockOutput),
        .audioMasterClock(audioMasterClock), .pixelEdges(pixelEdges), .audioEdges(audioEdges));

    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic finish_test();
        $display("Checks %0d, failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddress = a;
        regWriteData = d;
        regWrite = 1'b1;
        @(negedge clock);
        regWrite = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        regAddress = a;
        regRead = 1'b1;
        @(negedge clock);
        regRead = 1'b0;
    endtask

    // Only a hang lasts four thousand cycles.
    initial
    begin
        repeat (4000) @(posedge clock);
        failures++;
        finish_test();
    end

    initial
    begin
        {srst, regWrite, regRead, linkClockTick, linkPresent, acrPacketValid, countClear} = 7'b1000001;
        {regAddress, regWriteData, syncIn} = '0;
        pixelIn = 36'h9ABCD1234;
        audioIn = 6'h2A;
        bitsPerColour = 5'd12;
        pixelRepetition = 4'd1;
        acrN = 20'd1;
        acrCts = 20'd4;
        repeat (2) @(negedge clock);
        srst = 1'b0;
        countClear = 1'b0;
        foreach (rows[i])
        begin
            syncIn = rows[i].sync;
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr);
            @(negedge clock);
            check(regReadData, rows[i].rdExp);
            check({horizontalSync, verticalOrFieldPin, dataEnablePin}, rows[i].pins);
        end
        check(pixelOut, pixelIn);
        check(audioOutputPins, audioIn);
        linkPresent = 1'b1;
        linkClockTick = 1'b1;
        acrPacketValid = 1'b1;
        @(negedge clock);
        acrPacketValid = 1'b0;
        for (int n = 0; n < 100 && !(videoLocked === 1'b1 && audioLocked === 1'b1); n++)
            @(negedge clock);
        check({videoLocked, audioLocked}, 2'b11);
        countClear = 1'b1;
        @(negedge clock);
        countClear = 1'b0;
        repeat (48) @(negedge clock);
        check(pixelEdges >= 16'd7 && pixelEdges <= 16'd9, 1'b1);
        check(audioEdges >= 16'd5 && audioEdges <= 16'd7, 1'b1);
        linkPresent = 1'b0;
        linkClockTick = 1'b0;
        repeat (3) @(negedge clock);
        check({videoLocked, audioLocked, pixelClockOutput}, 3'b001);
        srst = 1'b1;
        repeat (2) @(negedge clock);
        srst = 1'b0;
        check({horizontalSync, verticalOrFieldPin, dataEnablePin, graphicsMode}, 4'b1101);
        foreach (resetAddr[i])
        begin
            rd(resetAddr[i]);
            @(negedge clock);
            check(regReadData, resetData[i]);
        end
        finish_test();
    end
endmodule // testbench
